// [shared/lsi_pkg.sv]
// Package of constants and types for the light sensor I2C target port.
package lsi_pkg;

  // ****************************************************************
  // Bus addressing
  // ****************************************************************
  localparam logic [6:0] ADDR_STRAP_GND = 7'h44;
  localparam logic [6:0] ADDR_STRAP_VDD = 7'h45;
  localparam logic [6:0] ADDR_STRAP_SDA = 7'h46;
  localparam logic [6:0] ADDR_STRAP_SCL = 7'h47;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [7:0] GENERAL_CALL_RESET = 8'h06;
  localparam logic [4:0] TOP_SPEED_CODE = 5'h01;

  // ****************************************************************
  // Strap encoding
  // ****************************************************************
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VDD = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_SCL = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int SCL_TIMEOUT_MS = 28;
  localparam int SCL_TIMEOUT_CYCLES = CLK_FREQ_HZ / 1000 * SCL_TIMEOUT_MS;
  localparam int STD_RATE_HZ = 100_000;
  localparam int FAST_RATE_HZ = 400_000;
  localparam int TOP_RATE_HZ = 2_600_000;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] POINTER_RESET = 8'h00;

  // ****************************************************************
  // Carried types
  // ****************************************************************
  typedef struct packed {
    logic scl;
    logic sdaIn;
  } lsi_bus_in_t;

  typedef struct packed {
    logic [7:0] pointer;
    logic [15:0] data;
  } lsi_reg_write_t;

endpackage

// [src/lsi_target_port.sv]
// I2C target port of the light sensor: framing, addressing, register access.

// Overview of operation
// - Acts only as a bus target, never drives the clock.
// - Works with bus clocks of 100 kHz, 400 kHz and 2.6 MHz.
// - Bus connects through a clock input and open-drain data line.
// - Data falling while clock high is a start; begins a transaction.
// - Address byte shifts in on clock rising edges; last bit is direction.
// - On matching address, data pulled low during the ninth clock.
// - Data moves in bytes, each followed by one acknowledge bit.
// - Data change while clock high counts as start or stop.
// - Data rising while clock high is a stop; ends the transfer.
// - Clock low for 28 ms resets the bus state machine.
// - Address byte is seven address bits plus one direction bit.
// - Strap picks address 1000100, 1000101, 1000110 or 1000111.
// - Strap sampled on every transaction; must be settled before traffic.
// - Every byte travels most significant bit first.
// - Write: address, pointer byte, two data bytes, each acknowledged.
// - Read returns pointed register high byte then low; pointer kept.
// - Top-speed code 00001xxx is not acknowledged but enables top speed.
// - General call then 06h is acknowledged and resets registers.
module lsi_target_port #(
  parameter int TIMEOUT_CYCLES = lsi_pkg::SCL_TIMEOUT_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire lsi_pkg::lsi_bus_in_t busIn,
  input wire logic [1:0] addrStrap,
  input wire logic [15:0] readData,
  output logic sdaOut,
  output logic sdaOe,
  output logic [7:0] regPointer,
  output lsi_pkg::lsi_reg_write_t regWrite,
  output logic regWriteStrobe,
  output logic generalReset,
  output logic topSpeedMode
);

  typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, RX, RX_ACK, TX, TX_ACK}
    lsi_state_t;

  lsi_state_t state;
  logic sclPrev;
  logic sdaPrev;
  logic [7:0] shift;
  logic [3:0] bitCount;
  logic [1:0] byteIndex;
  logic isRead;
  logic isGeneral;
  logic [6:0] ownAddr;
  logic [7:0] highByte;
  logic [31:0] lowCount;
  logic [15:0] txWord;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic timeout;
  logic [7:0] rxByte;

  // ****************************************************************
  // Bus condition detection
  // ****************************************************************

  // The pins are taken as synchronous; only a one-cycle history is kept.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclPrev <= busIn.scl;
      sdaPrev <= busIn.sdaIn;
    end
  end

  // Clock edges and the two framing conditions.
  assign sclRise = busIn.scl && !sclPrev;
  assign sclFall = !busIn.scl && sclPrev;
  assign startSeen = busIn.scl && sclPrev && sdaPrev && !busIn.sdaIn;
  assign stopSeen = busIn.scl && sclPrev && !sdaPrev && busIn.sdaIn;
  assign rxByte = {shift[6:0], busIn.sdaIn};

  // Clock-low watchdog; it only runs while a transaction is open.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || busIn.scl || state == IDLE)
      lowCount <= '0;
    else if (lowCount < 32'(TIMEOUT_CYCLES))
      lowCount <= lowCount + 32'h1;
  end
  assign timeout = lowCount >= 32'(TIMEOUT_CYCLES);

  // Strap decode; the strap is read afresh at every start.
  function automatic logic [6:0] strapAddr(input logic [1:0] s);
    unique case (s)
      lsi_pkg::STRAP_GND: strapAddr = lsi_pkg::ADDR_STRAP_GND;
      lsi_pkg::STRAP_VDD: strapAddr = lsi_pkg::ADDR_STRAP_VDD;
      lsi_pkg::STRAP_SDA: strapAddr = lsi_pkg::ADDR_STRAP_SDA;
      lsi_pkg::STRAP_SCL: strapAddr = lsi_pkg::ADDR_STRAP_SCL;
    endcase
  endfunction

  // ****************************************************************
  // Transaction state machine
  // ****************************************************************

  // Bits are sampled on rising clock edges, MSB first; the state moves on the
  // falling edge so the data line only changes while the clock is low.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || timeout)
    begin
      state <= IDLE;
      shift <= 8'h00;
      bitCount <= 4'h0;
      byteIndex <= 2'h0;
      isRead <= 1'b0;
      isGeneral <= 1'b0;
      ownAddr <= lsi_pkg::ADDR_STRAP_GND;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      regWriteStrobe <= 1'b0;
      generalReset <= 1'b0;
      highByte <= 8'h00;
      txWord <= 16'h0000;
    end
    else
    begin
      regWriteStrobe <= 1'b0;
      generalReset <= 1'b0;
      sdaOut <= 1'b0;
      if (startSeen)
      begin
        state <= ADDR;
        bitCount <= 4'h0;
        byteIndex <= 2'h0;
        sdaOe <= 1'b0;
        ownAddr <= strapAddr(addrStrap);
      end
      else if (stopSeen)
      begin
        state <= IDLE;
        sdaOe <= 1'b0;
      end
      else if (sclRise && (state == ADDR || state == RX))
      begin
        shift <= rxByte;
        bitCount <= bitCount + 4'h1;
      end
      else if (sclRise && state == TX_ACK && busIn.sdaIn)
        state <= IDLE; // Controller not-acknowledge ends the read.
      else if (sclFall)
      begin
        unique case (state)
          IDLE: sdaOe <= 1'b0;
          ADDR:
            if (bitCount == 4'h8)
            begin
              bitCount <= 4'h0;
              isRead <= shift[0];
              isGeneral <= shift[7:1] == lsi_pkg::GENERAL_CALL_ADDR;
              if (shift[7:1] == ownAddr
                  || (shift[7:1] == lsi_pkg::GENERAL_CALL_ADDR && !shift[0]))
              begin
                state <= ADDR_ACK;
                sdaOe <= 1'b1;
                txWord <= readData;
              end
              else
                state <= IDLE; // Top-speed code and foreign addresses stay silent.
            end
          ADDR_ACK:
          begin
            if (isRead)
            begin
              state <= TX;
              sdaOe <= !txWord[15];
              txWord <= {txWord[14:0], 1'b0};
              bitCount <= 4'h1;
            end
            else
            begin
              state <= RX;
              sdaOe <= 1'b0;
            end
          end
          RX:
            if (bitCount == 4'h8)
            begin
              bitCount <= 4'h0;
              state <= RX_ACK;
              sdaOe <= !isGeneral || shift == lsi_pkg::GENERAL_CALL_RESET;
              if (isGeneral)
                generalReset <= shift == lsi_pkg::GENERAL_CALL_RESET;
              else if (byteIndex == 2'h1)
                highByte <= shift;
              else if (byteIndex == 2'h2)
                regWriteStrobe <= 1'b1;
              if (byteIndex != 2'h3)
                byteIndex <= byteIndex + 2'h1;
            end
          RX_ACK:
          begin
            sdaOe <= 1'b0;
            state <= (isGeneral || byteIndex == 2'h3) ? IDLE : RX;
          end
          TX:
            if (bitCount == 4'h8)
            begin
              bitCount <= 4'h0;
              state <= TX_ACK;
              sdaOe <= 1'b0;
            end
            else
            begin
              sdaOe <= !txWord[15];
              txWord <= {txWord[14:0], 1'b0};
              bitCount <= bitCount + 4'h1;
            end
          TX_ACK:
          begin
            state <= TX; // Controller acked; low byte follows, then zeros.
            sdaOe <= !txWord[15];
            txWord <= {txWord[14:0], 1'b0};
            bitCount <= 4'h1;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Register pointer and write data
  // ****************************************************************

  // The pointer survives reads and stops; only a write or reset changes it.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || generalReset)
      regPointer <= lsi_pkg::POINTER_RESET;
    else if (sclFall && state == RX && bitCount == 4'h8 && byteIndex == 2'h0 && !isGeneral)
      regPointer <= shift;
  end

  // Write word is presented with the strobe, high byte first on the bus.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      regWrite <= '0;
    else if (sclFall && state == RX && bitCount == 4'h8 && byteIndex == 2'h2 && !isGeneral)
      regWrite <= '{pointer: regPointer, data: {highByte, shift}};
  end

  // Top-speed mode: entered on the controller code, left on stop.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || stopSeen)
      topSpeedMode <= 1'b0;
    else if (sclFall && state == ADDR && bitCount == 4'h8
             && shift[7:3] == lsi_pkg::TOP_SPEED_CODE)
      topSpeedMode <= 1'b1;
  end

endmodule

// [testbench/lsi_target_port_asserts.sv]
// Checker of the target port's behaviour on the bus and on its strobes.
module lsi_target_port_asserts #(
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire lsi_pkg::lsi_bus_in_t busIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [7:0] regPointer,
  input wire lsi_pkg::lsi_reg_write_t regWrite,
  input wire logic regWriteStrobe,
  input wire logic generalReset,
  input wire logic topSpeedMode
);
  timeunit 1ns;
  timeprecision 100ps;
  int lowCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ****************************************************************
  // Bus events
  // ****************************************************************
  sequence s_sclHigh;
    busIn.scl ##1 busIn.scl;
  endsequence
  sequence s_stop;
    s_sclHigh ##0 $rose(busIn.sdaIn);
  endsequence
  // Length of the current clock-low phase; saturates so it never wraps.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || busIn.scl)
      lowCnt <= 0;
    else if (lowCnt < TIMEOUT_CYCLES + 9)
      lowCnt <= lowCnt + 1;
  end
  AST_SDA_LOW_ONLY: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  AST_ACK_START: assert property ($rose(sdaOe) |-> !busIn.scl)
    else $error("data pulled while clock high");
  AST_HOLD_HIGH: assert property (s_sclHigh |-> $stable(sdaOe))
    else $error("data changed while clock high");
  AST_RELEASE_LOW: assert property ($fell(sdaOe) |-> !busIn.scl)
    else $error("data released while clock high");
  AST_STROBE_PULSE: assert property (regWriteStrobe |=> !regWriteStrobe)
    else $error("write strobe longer than one cycle");
  AST_WRITE_PTR: assert property (regWriteStrobe |-> regWrite.pointer == regPointer)
    else $error("write carries wrong pointer");
  AST_GC_PTR: assert property (generalReset |-> ##[0:1] regPointer == 8'h00)
    else $error("pointer not cleared by general reset");
  AST_TOP_STOP: assert property (s_stop |-> ##[1:4] !topSpeedMode)
    else $error("top speed kept after stop");
  // The margin covers the cycle the design takes to release the line after its count runs out.
  AST_TIMEOUT: assert property (lowCnt == TIMEOUT_CYCLES + 8 |-> !sdaOe)
    else $error("data held after clock timeout");
endmodule

bind lsi_target_port lsi_target_port_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .core_clk, .reset_n, .busIn, .sdaOut, .sdaOe, .regPointer, .regWrite,
  .regWriteStrobe, .generalReset, .topSpeedMode);

// [testbench/lsi_bus_ctrl.sv]
// Behavioural bus controller that drives the target port from the far side.
module lsi_bus_ctrl (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sdaPull
);
  timeunit 1ns;
  timeprecision 100ps;
  // Half bus-clock period in core clocks; the bench sets the speed.
  int h = 40;
  initial
  begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // Steps just past an edge so no change races the design's sampling.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sdaPull = 1'b0;
    tick(h);
    scl = 1'b1;
    tick(h);
    sdaPull = 1'b1;
    tick(h);
    scl = 1'b0;
    tick(h);
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    sdaPull = 1'b1;
    tick(h);
    scl = 1'b1;
    tick(h);
    sdaPull = 1'b0;
    tick(h);
  endtask
  // Eight bits then the acknowledge slot; a one in tx releases the line.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sdaPull = !tx[i];
      tick(h);
      scl = 1'b1;
      tick(h);
      rx[i] = sda;
      scl = 1'b0;
      tick(2);
    end
  endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the light sensor I2C target port.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TMO = 2000;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] addrStrap = 2'h0;
  logic sdaOut, sdaOe, regWriteStrobe, generalReset, topSpeedMode, scl, sdaPull;
  logic [7:0] regPointer;
  logic [15:0] readData;
  logic [8:0] rx;
  lsi_pkg::lsi_reg_write_t regWrite, lastWr;
  lsi_pkg::lsi_bus_in_t busIn;
  wire sda = !sdaPull && (sdaOe ? sdaOut : 1'b1);
  int err_total = 0;
  int n_compared = 0;
  int nWr = 0;
  int nGc = 0;
  // Rows: half period, strap, address byte, expected acknowledge level.
  int rows [7][4] = '{'{625, 0, 'h88, 0}, '{156, 1, 'h8A, 0}, '{40, 2, 'h8C, 0},
    '{40, 3, 'h8E, 0}, '{40, 0, 'h8A, 1}, '{40, 2, 'h01, 1}, '{40, 1, 'h88, 1}};
  logic [7:0] wb [4] = '{8'h88, 8'h5A, 8'hC3, 8'h21};
  // The pull-up gives a high level whenever nobody pulls the data line.
  assign busIn = {scl, sda};
  assign readData = {regPointer, 8'h3C};
  always #4 core_clk = !core_clk;
  lsi_target_port #(.TIMEOUT_CYCLES(TMO)) i_lsi_target_port (.core_clk, .reset_n,
    .busIn, .addrStrap, .readData, .sdaOut, .sdaOe, .regPointer, .regWrite,
    .regWriteStrobe, .generalReset, .topSpeedMode);
  lsi_bus_ctrl i_lsi_bus_ctrl (.core_clk, .sda, .scl, .sdaPull);
  // Records strobed writes and reset pulses for later comparison.
  always @(posedge core_clk)
  begin
    if (regWriteStrobe)
      lastWr <= regWrite;
    nWr <= nWr + int'(regWriteStrobe);
    nGc <= nGc + int'(generalReset);
  end
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cuts a hang short at well over the expected run length.
  initial
  begin
    repeat (80000) @(posedge core_clk);
    err_total++;
    test_done();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    @(posedge core_clk);
    #1;
    cmp(24'({sdaOut, sdaOe, topSpeedMode, regPointer}), 24'h0);
    $display("reset test done");
    foreach (rows[k])
    begin
      i_lsi_bus_ctrl.h = rows[k][0];
      addrStrap = 2'(rows[k][1]);
      i_lsi_bus_ctrl.start();
      i_lsi_bus_ctrl.xfer({rows[k][2][7:0], 1'b1}, rx);
      cmp(24'(rx[0]), 24'(rows[k][3]));
      i_lsi_bus_ctrl.stop();
      $display("row %0d done", k);
    end
    i_lsi_bus_ctrl.h = 40;
    addrStrap = 2'h0;
    i_lsi_bus_ctrl.start();
    foreach (wb[j])
    begin
      i_lsi_bus_ctrl.xfer({wb[j], 1'b1}, rx);
      cmp(24'(rx[0]), 24'h0);
    end
    i_lsi_bus_ctrl.stop();
    cmp(lastWr, 24'h5AC321);
    cmp(24'(nWr), 24'h1);
    $display("write test done");
    // Read twice without a new pointer write; the pointer must persist.
    repeat (2)
    begin
      i_lsi_bus_ctrl.start();
      i_lsi_bus_ctrl.xfer(9'h113, rx);
      cmp(24'(rx[0]), 24'h0);
      i_lsi_bus_ctrl.xfer(9'h1FE, rx);
      cmp(24'(rx[8:1]), 24'h5A);
      i_lsi_bus_ctrl.xfer(9'h1FF, rx);
      cmp(24'(rx[8:1]), 24'h3C);
      i_lsi_bus_ctrl.stop();
    end
    $display("read test done");
    // The first data bit of 0x5A is low, so the port is pulling when stalled.
    i_lsi_bus_ctrl.start();
    i_lsi_bus_ctrl.xfer(9'h113, rx);
    cmp(24'(sdaOe), 24'h1);
    i_lsi_bus_ctrl.tick(TMO + 20);
    cmp(24'(sdaOe), 24'h0);
    i_lsi_bus_ctrl.stop();
    $display("timeout test done");
    // The top-speed code goes out at the fast rate; what follows runs near 2.5 MHz.
    i_lsi_bus_ctrl.h = 156;
    i_lsi_bus_ctrl.start();
    i_lsi_bus_ctrl.xfer(9'h01B, rx);
    cmp(24'({rx[0], topSpeedMode}), 24'h3);
    i_lsi_bus_ctrl.h = 24;
    i_lsi_bus_ctrl.start();
    i_lsi_bus_ctrl.xfer(9'h111, rx);
    cmp(24'(rx[0]), 24'h0);
    i_lsi_bus_ctrl.stop();
    cmp(24'(topSpeedMode), 24'h0);
    $display("top speed test done");
    i_lsi_bus_ctrl.h = 40;
    i_lsi_bus_ctrl.start();
    i_lsi_bus_ctrl.xfer(9'h001, rx);
    cmp(24'(rx[0]), 24'h0);
    i_lsi_bus_ctrl.xfer(9'h00D, rx);
    cmp(24'(rx[0]), 24'h0);
    i_lsi_bus_ctrl.stop();
    cmp(24'({nGc[7:0], regPointer}), 24'h100);
    $display("general call test done");
    test_done();
  end
endmodule
